// ---- rtl/fio_params.svh ----
// Offsets, field positions, reset values and timing counts of the fast I/O mode selector.
`ifndef FIO_PARAMS_SVH
`define FIO_PARAMS_SVH

`define FIO_CLK_HZ 40000000
`define FIO_MS_CYCLES (`FIO_CLK_HZ / 1000)
`define FIO_STEP_MAX_HZ 10000
`define FIO_STEP_MIN_HALF ((`FIO_CLK_HZ + 2 * `FIO_STEP_MAX_HZ - 1) / (2 * `FIO_STEP_MAX_HZ))
`define FIO_FILT_DEFAULT_MS 7'h0A
`define FIO_FILT_MAX_MS 7'h63

`define FIO_ADDR_MODE 8'h00
`define FIO_ADDR_CTRL 8'h04
`define FIO_ADDR_FILTER 8'h08
`define FIO_ADDR_STATUS 8'h0C
`define FIO_ADDR_COUNT1 8'h10
`define FIO_ADDR_COUNT2 8'h14
`define FIO_ADDR_PRESET1 8'h18
`define FIO_ADDR_PRESET2 8'h1C
`define FIO_ADDR_STEP_RATE 8'h20
`define FIO_ADDR_STEP_CMD 8'h24
`define FIO_ADDR_TIMER 8'h28
`define FIO_ADDR_OUTPUT 8'h2C

`define FIO_MODE_RESET 16'h0060
`define FIO_MODE_CODE_COUNT 8'h10
`define FIO_MODE_CODE_UPDOWN 8'h20
`define FIO_MODE_CODE_STEP 8'h30
`define FIO_MODE_CODE_INTR 8'h40
`define FIO_MODE_CODE_CATCH 8'h50
`define FIO_MODE_CODE_FILTER 8'h60

`define FIO_CTRL_QUAD 0
`define FIO_CTRL_CWCCW 1
`define FIO_CTRL_RESET_EN 2
`define FIO_CTRL_TIMER_INT 3
`define FIO_CTRL_CATCH_LO 4
`define FIO_CTRL_RESET 8'h04

`define FIO_FLAG_PRESET1 0
`define FIO_FLAG_PRESET2 1
`define FIO_FLAG_EDGE_INT 2
`define FIO_FLAG_TIMER_INT 3
`define FIO_FLAG_CAUGHT 4
`define FIO_FLAG_STEP_DONE 5
`define FIO_STAT_FILT_LO 8
`define FIO_STAT_STEP_BUSY 12
`define FIO_STAT_QUAD_DIR 13

`define FIO_STEP_DIR_BIT 31
`define FIO_STEP_RATE_RESET 16'h07D0
`define FIO_TIMER_RESET 32'h00009C40

`endif

// ---- rtl/fio_pkg.sv ----
// Types shared by the fast I/O mode selector and its bench.
package fio_pkg;

	typedef enum logic [5:0] {
		MODE_COUNT = 6'h01,
		MODE_UPDOWN = 6'h02,
		MODE_STEP = 6'h04,
		MODE_INTR = 6'h08,
		MODE_CATCH = 6'h10,
		MODE_FILTER = 6'h20
	} mode_e_t;

	typedef enum logic [1:0] {
		STEP_IDLE = 2'h1,
		STEP_RUN = 2'h2
	} step_e_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} avmm_req_t;

	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
		logic [15:0] mode_word;
		logic [7:0] ctrl;
		logic [6:0] filt_on;
		logic [6:0] filt_off;
		logic [1:0] out_reg;
		logic [1:0][31:0] count;
		logic [1:0][31:0] preset;
		logic [31:0] timer_ival;
		logic [31:0] timer_cnt;
		logic [15:0] ms_cnt;
		logic [3:0][6:0] fcnt;
		logic [3:0] filt;
		logic [3:0] prev;
		logic [3:0] fin_vis;
		logic [5:0] flags;
		logic quad_dir;
		step_e_t step_state;
		logic [15:0] step_half;
		logic [15:0] step_tmr;
		logic [23:0] step_left;
		logic step_dir;
		logic step_phase;
		logic [1:0] fout;
	} state_t;

endpackage : fio_pkg

// ---- rtl/fast_io_mode_selector.sv ----
// Dedicated fast I/O unit: mode decode, counters, stepper pulses, interrupts, catch and filters.
`timescale 1ns/1ps
`include "fio_params.svh"

module fast_io_mode_selector #(
	parameter int P_MS_CYCLES = `FIO_MS_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire fio_pkg::avmm_req_t i_avmm,
	output logic o_waitrequest,
	output logic [31:0] o_readdata,
	input wire logic [3:0] i_fast_input,
	output logic [1:0] o_fast_output,
	output logic [3:0] o_filtered_input
);

	fio_pkg::state_t st;
	fio_pkg::state_t next_st;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	fio_pkg::mode_e_t mode;
	logic [3:0] rise;
	logic [3:0] used;
	logic [5:0] set_f;
	logic [5:0] clr_f;
	logic ms_tick;
	logic [6:0] dly;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [1:0] cnt_sel;

	// Any code outside the six falls back to plain filtered points.
	always_comb begin
		case (st.mode_word[7:0])
			`FIO_MODE_CODE_COUNT: mode = fio_pkg::MODE_COUNT;
			`FIO_MODE_CODE_UPDOWN: mode = fio_pkg::MODE_UPDOWN;
			`FIO_MODE_CODE_STEP: mode = fio_pkg::MODE_STEP;
			`FIO_MODE_CODE_INTR: mode = fio_pkg::MODE_INTR;
			`FIO_MODE_CODE_CATCH: mode = fio_pkg::MODE_CATCH;
			default: mode = fio_pkg::MODE_FILTER;
		endcase
	end

	always_comb begin
		next_st = st;
		rise = i_fast_input & ~st.prev;
		next_st.prev = i_fast_input;
		set_f = 6'h00;
		clr_f = 6'h00;
		used = 4'h0;
		cnt_sel = st.ctrl[`FIO_CTRL_CATCH_LO +: 2];
		wr = i_avmm.write && !st.waitrequest;
		wdata = 32'h00000000;
		rdata = 32'h00000000;
		dly = 7'h00;

		// Millisecond time base for the filters runs regardless of software activity.
		ms_tick = (st.ms_cnt == 16'(P_MS_CYCLES - 1));
		next_st.ms_cnt = ms_tick ? 16'h0000 : st.ms_cnt + 16'h0001;

		for (int i = 0; i < 4; i++) begin
			dly = i_fast_input[i] ? st.filt_on : st.filt_off;
			if (i_fast_input[i] == st.filt[i]) begin
				next_st.fcnt[i] = 7'h00;
			end else if (dly == 7'h00) begin
				next_st.filt[i] = i_fast_input[i];
			end else if (ms_tick) begin
				if (st.fcnt[i] + 7'h01 >= dly) begin
					next_st.filt[i] = i_fast_input[i];
					next_st.fcnt[i] = 7'h00;
				end else begin
					next_st.fcnt[i] = st.fcnt[i] + 7'h01;
				end
			end
		end

		// Only the decoded mode's function runs on the dedicated points.
		case (mode)
			fio_pkg::MODE_COUNT: begin
				used = st.ctrl[`FIO_CTRL_RESET_EN] ? 4'hF : 4'h3;
				for (int c = 0; c < 2; c++) begin
					if (st.ctrl[`FIO_CTRL_RESET_EN] && i_fast_input[c + 2]) begin
						next_st.count[c] = 32'h00000000;
					end else if (rise[c]) begin
						next_st.count[c] = st.count[c] + 32'h00000001;
						if (st.count[c] + 32'h00000001 == st.preset[c]) begin
							set_f[c] = 1'b1;
						end
					end
				end
			end
			fio_pkg::MODE_UPDOWN: begin
				used = st.ctrl[`FIO_CTRL_RESET_EN] ? 4'h7 : 4'h3;
				if (st.ctrl[`FIO_CTRL_RESET_EN] && i_fast_input[2]) begin
					next_st.count[0] = 32'h00000000;
				end else if (st.ctrl[`FIO_CTRL_QUAD]) begin
					// Leading edge of phase A counts; phase B level gives the direction.
					if (rise[0]) begin
						next_st.quad_dir = i_fast_input[1];
						next_st.count[0] = i_fast_input[1] ? st.count[0] - 32'h00000001
							: st.count[0] + 32'h00000001;
					end
				end else if (rise[0] && !rise[1]) begin
					next_st.count[0] = st.count[0] + 32'h00000001;
				end else if (rise[1] && !rise[0]) begin
					next_st.count[0] = st.count[0] - 32'h00000001;
				end
				if (next_st.count[0] != st.count[0] && next_st.count[0] == st.preset[0]
					&& !(st.ctrl[`FIO_CTRL_RESET_EN] && i_fast_input[2])) begin
					set_f[`FIO_FLAG_PRESET1] = 1'b1;
				end
			end
			fio_pkg::MODE_INTR: begin
				used = 4'h1;
				if (st.ctrl[`FIO_CTRL_TIMER_INT]) begin
					if (st.timer_cnt + 32'h00000001 >= st.timer_ival) begin
						next_st.timer_cnt = 32'h00000000;
						set_f[`FIO_FLAG_TIMER_INT] = 1'b1;
					end else begin
						next_st.timer_cnt = st.timer_cnt + 32'h00000001;
					end
				end else if (rise[0]) begin
					set_f[`FIO_FLAG_EDGE_INT] = 1'b1;
				end
			end
			fio_pkg::MODE_CATCH: begin
				// The raw pin is watched every 25 ns, far finer than the shortest pulse.
				used = 4'h1 << cnt_sel;
				if (rise[cnt_sel]) begin
					set_f[`FIO_FLAG_CAUGHT] = 1'b1;
				end
			end
			fio_pkg::MODE_STEP: used = 4'h0;
			fio_pkg::MODE_FILTER: used = 4'h0;
			default: used = 4'h0;
		endcase
		if (mode != fio_pkg::MODE_INTR) begin
			next_st.timer_cnt = 32'h00000000;
		end

		// Stepper pulse engine; a mode change aborts any move in progress.
		case (st.step_state)
			fio_pkg::STEP_IDLE: begin
				next_st.step_phase = 1'b0;
			end
			fio_pkg::STEP_RUN: begin
				if (mode != fio_pkg::MODE_STEP) begin
					next_st.step_state = fio_pkg::STEP_IDLE;
				end else if (st.step_tmr + 16'h0001 >= st.step_half) begin
					next_st.step_tmr = 16'h0000;
					next_st.step_phase = !st.step_phase;
					if (st.step_phase) begin
						next_st.step_left = st.step_left - 24'h000001;
						if (st.step_left == 24'h000001) begin
							next_st.step_state = fio_pkg::STEP_IDLE;
							set_f[`FIO_FLAG_STEP_DONE] = 1'b1;
						end
					end
				end else begin
					next_st.step_tmr = st.step_tmr + 16'h0001;
				end
			end
			default: next_st.step_state = fio_pkg::STEP_IDLE;
		endcase

		// Register reads and writes; a write wins over the hardware update it meets, except a status clear, which loses to a flag set in the same cycle.
		case (i_avmm.address)
			`FIO_ADDR_MODE: rdata = {16'h0000, st.mode_word};
			`FIO_ADDR_CTRL: rdata = {24'h000000, st.ctrl};
			`FIO_ADDR_FILTER: rdata = {17'h00000, st.filt_off, 1'b0, st.filt_on};
			`FIO_ADDR_STATUS: rdata = {18'h00000, st.quad_dir,
				st.step_state == fio_pkg::STEP_RUN, st.fin_vis, 2'h0, st.flags};
			`FIO_ADDR_COUNT1: rdata = st.count[0];
			`FIO_ADDR_COUNT2: rdata = st.count[1];
			`FIO_ADDR_PRESET1: rdata = st.preset[0];
			`FIO_ADDR_PRESET2: rdata = st.preset[1];
			`FIO_ADDR_STEP_RATE: rdata = {16'h0000, st.step_half};
			`FIO_ADDR_STEP_CMD: rdata = {st.step_dir, 7'h00, st.step_left};
			`FIO_ADDR_TIMER: rdata = st.timer_ival;
			`FIO_ADDR_OUTPUT: rdata = {30'h00000000, st.out_reg};
			default: rdata = 32'h00000000;
		endcase
		wdata = merge(rdata, i_avmm.writedata, i_avmm.byteenable);
		if (wr) begin
			case (i_avmm.address)
				`FIO_ADDR_MODE: next_st.mode_word = wdata[15:0];
				`FIO_ADDR_CTRL: next_st.ctrl = wdata[7:0];
				`FIO_ADDR_FILTER: begin
					next_st.filt_on = (wdata[6:0] > `FIO_FILT_MAX_MS) ? `FIO_FILT_MAX_MS
						: wdata[6:0];
					next_st.filt_off = (wdata[14:8] > `FIO_FILT_MAX_MS) ? `FIO_FILT_MAX_MS
						: wdata[14:8];
				end
				`FIO_ADDR_STATUS: clr_f = wdata[5:0];
				`FIO_ADDR_COUNT1: next_st.count[0] = wdata;
				`FIO_ADDR_COUNT2: next_st.count[1] = wdata;
				`FIO_ADDR_PRESET1: next_st.preset[0] = wdata;
				`FIO_ADDR_PRESET2: next_st.preset[1] = wdata;
				`FIO_ADDR_STEP_RATE: begin
					// Clamping keeps the pulse rate at or below the drive's limit.
					next_st.step_half = (wdata[15:0] < 16'(`FIO_STEP_MIN_HALF))
						? 16'(`FIO_STEP_MIN_HALF) : wdata[15:0];
				end
				`FIO_ADDR_STEP_CMD: begin
					if (mode == fio_pkg::MODE_STEP && wdata[23:0] != 24'h000000) begin
						next_st.step_left = wdata[23:0];
						next_st.step_dir = wdata[`FIO_STEP_DIR_BIT];
						next_st.step_tmr = 16'h0000;
						next_st.step_phase = 1'b0;
						next_st.step_state = fio_pkg::STEP_RUN;
					end
				end
				`FIO_ADDR_TIMER: next_st.timer_ival = wdata;
				`FIO_ADDR_OUTPUT: next_st.out_reg = wdata[1:0];
				default: next_st.ctrl = st.ctrl;
			endcase
		end
		next_st.flags = (st.flags & ~clr_f) | set_f;

		// One-cycle answer: waitrequest drops for the cycle after a request is seen.
		next_st.waitrequest = !((i_avmm.read || i_avmm.write) && st.waitrequest);
		if ((i_avmm.read || i_avmm.write) && st.waitrequest) begin
			next_st.readdata = i_avmm.read ? rdata : 32'h00000000;
		end

		// Points assigned to the mode are hidden from the regular input image.
		next_st.fin_vis = st.filt & ~used;

		if (mode == fio_pkg::MODE_STEP) begin
			if (st.ctrl[`FIO_CTRL_CWCCW]) begin
				next_st.fout[0] = st.step_phase && !st.step_dir;
				next_st.fout[1] = st.step_phase && st.step_dir;
			end else begin
				next_st.fout[0] = st.step_phase;
				next_st.fout[1] = st.step_dir;
			end
		end else begin
			next_st.fout = st.out_reg;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st <= '0;
			st.waitrequest <= 1'b1;
			st.mode_word <= `FIO_MODE_RESET;
			st.ctrl <= `FIO_CTRL_RESET;
			st.filt_on <= `FIO_FILT_DEFAULT_MS;
			st.filt_off <= `FIO_FILT_DEFAULT_MS;
			st.timer_ival <= `FIO_TIMER_RESET;
			st.step_half <= `FIO_STEP_RATE_RESET;
			st.step_state <= fio_pkg::STEP_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign o_waitrequest = st.waitrequest;
	assign o_readdata = st.readdata;
	assign o_fast_output = st.fout;
	assign o_filtered_input = st.fin_vis;

endmodule : fast_io_mode_selector

// ---- tb/fio_chk_props.sv ----
// Port checker of the fast I/O mode selector.
`timescale 1ns/1ps
`include "fio_params.svh"
module fio_chk (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire fio_pkg::avmm_req_t i_avmm,
	input wire logic o_waitrequest,
	input wire logic [31:0] o_readdata,
	input wire logic [1:0] o_fast_output,
	input wire logic [3:0] o_filtered_input
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic req;
	logic acc;
	logic wr_out;
	logic step;
	logic [2:0] hist;
	logic [15:0] mode;
	logic [15:0] hi;
	assign req = (i_avmm.read || i_avmm.write) && o_waitrequest;
	assign acc = i_avmm.write && !o_waitrequest;
	assign wr_out = acc && i_avmm.address == `FIO_ADDR_OUTPUT;
	assign step = mode[7:0] == `FIO_MODE_CODE_STEP;
	// Outputs lag the mode by a register, so a short history excuses the hand-over.
	always_ff @(posedge i_core_clk) begin
		hist <= i_rst ? 3'h0 : {hist[1:0], step};
		hi <= o_fast_output[0] ? hi + 16'h1 : 16'h0;
		if (i_rst)
			mode <= `FIO_MODE_RESET;
		else if (acc && i_avmm.address == `FIO_ADDR_MODE)
			mode <= i_avmm.writedata[15:0];
	end
	a_ack_next: assert property (req |=> !o_waitrequest)
		else $error("request not answered next cycle");
	a_ack_single: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("answer longer than one cycle");
	a_no_idle_ack: assert property (!(i_avmm.read || i_avmm.write) && o_waitrequest
		|=> o_waitrequest)
		else $error("answer without request");
	a_mode_read: assert property (req && i_avmm.read && i_avmm.address == `FIO_ADDR_MODE
		|=> o_readdata == {16'h0000, mode})
		else $error("mode word read wrong");
	a_unmapped_zero: assert property (req && i_avmm.read && i_avmm.address >= 8'h30
		|=> o_readdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_reset_quiet: assert property ($fell(i_rst) |-> o_waitrequest
		&& o_fast_output == 2'h0 && o_filtered_input == 4'h0)
		else $error("outputs not quiet after reset");
	a_out_regular: assert property ($changed(o_fast_output) && !step && hist == 3'h0
		|-> $past(wr_out) || $past(wr_out, 2) || $past(wr_out, 3))
		else $error("regular output moved without a write");
	a_step_half: assert property ($fell(o_fast_output[0]) && step
		|-> hi >= 16'h07D0)
		else $error("step pulse faster than allowed");
endmodule : fio_chk
bind fast_io_mode_selector fio_chk u_chk (.*);

// ---- tb/fio_field.sv ----
// Field-side model: sensors on the inputs and a stepper drive on the outputs.
`timescale 1ns/1ps
module fio_field (
	input wire logic i_clk,
	input wire logic [1:0] i_step,
	output logic [3:0] o_pins
);
	int steps = 0;
	logic dir = 1'b0;
	logic last = 1'b0;
	initial o_pins = 4'h0;
	// The drive latches direction at each rising pulse, as a real driver does.
	always @(posedge i_clk) begin
		last <= i_step[0];
		if (i_step[0] && !last) begin
			steps <= steps + 1;
			dir <= i_step[1];
		end
	end
	task automatic lvl(input int ch, input logic v);
		@(posedge i_clk);
		o_pins[ch] <= v;
	endtask : lvl
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			lvl(ch, 1'b1);
			repeat (3) @(posedge i_clk);
			lvl(ch, 1'b0);
			repeat (3) @(posedge i_clk);
		end
	endtask : pulse
endmodule : fio_field

// ---- tb/fast_io_mode_selector_bench.sv ----
// Self-checking bench of the fast I/O mode selector.
`timescale 1ns/1ps
`include "fio_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module fast_io_mode_selector_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	fio_pkg::avmm_req_t av = '0;
	logic wt;
	logic [31:0] rdat;
	logic [3:0] pins;
	logic [1:0] outs;
	logic [3:0] filt;
	logic [31:0] d;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	fast_io_mode_selector #(.P_MS_CYCLES(4)) u_dut (.i_core_clk(clk), .i_rst(rst),
		.i_avmm(av), .o_waitrequest(wt), .o_readdata(rdat), .i_fast_input(pins),
		.o_fast_output(outs), .o_filtered_input(filt));
	fio_field u_fld (.i_clk(clk), .i_step(outs), .o_pins(pins));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Values are read before the edge's updates land, so no race with the slave.
	// Only the bench's cycle ceiling may end this wait.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		av <= '{read: !w, write: w, address: a, byteenable: 4'hF, writedata: wd};
		do begin
			@(posedge clk);
		end while (wt !== 1'b0);
		d = rdat;
		av <= '0;
	endtask : bus
	task automatic t_defaults;
		bus(0, `FIO_ADDR_MODE, 32'h0);
		`CHK(d, 32'h00000060)
		bus(0, `FIO_ADDR_FILTER, 32'h0);
		`CHK(d[14:0], 15'h0A0A)
		bus(0, 8'h40, 32'h0);
		`CHK(d, 32'h00000000)
		u_fld.lvl(3, 1'b1);
		repeat (30) @(posedge clk);
		`CHK(filt[3], 1'b0)
		repeat (50) @(posedge clk);
		`CHK(filt[3], 1'b1)
		u_fld.lvl(3, 1'b0);
	endtask : t_defaults
	task automatic t_count;
		bus(1, `FIO_ADDR_MODE, 32'h10);
		bus(1, `FIO_ADDR_PRESET1, 32'h2);
		u_fld.pulse(0, 3);
		u_fld.pulse(1, 2);
		bus(0, `FIO_ADDR_COUNT1, 32'h0);
		`CHK(d, 32'h00000003)
		bus(0, `FIO_ADDR_COUNT2, 32'h0);
		`CHK(d, 32'h00000002)
		bus(0, `FIO_ADDR_STATUS, 32'h0);
		`CHK(d[0], 1'b1)
		u_fld.pulse(2, 1);
		bus(0, `FIO_ADDR_COUNT1, 32'h0);
		`CHK(d, 32'h00000000)
		bus(1, `FIO_ADDR_OUTPUT, 32'h2);
		repeat (3) @(posedge clk);
		`CHK(outs, 2'h2)
	endtask : t_count
	task automatic t_updown;
		bus(1, `FIO_ADDR_MODE, 32'h20);
		bus(1, `FIO_ADDR_CTRL, 32'h0);
		bus(1, `FIO_ADDR_COUNT1, 32'h0);
		u_fld.pulse(0, 4);
		u_fld.pulse(1, 1);
		bus(0, `FIO_ADDR_COUNT1, 32'h0);
		`CHK(d, 32'h00000003)
		bus(1, `FIO_ADDR_CTRL, 32'h1);
		u_fld.lvl(1, 1'b1);
		u_fld.pulse(0, 2);
		bus(0, `FIO_ADDR_COUNT1, 32'h0);
		`CHK(d, 32'h00000001)
		u_fld.lvl(1, 1'b0);
	endtask : t_updown
	task automatic t_step;
		int n;
		bus(1, `FIO_ADDR_MODE, 32'h30);
		bus(1, `FIO_ADDR_STEP_CMD, 32'h80000002);
		n = 0;
		do begin
			bus(0, `FIO_ADDR_STATUS, 32'h0);
			n++;
		end while (d[5] !== 1'b1 && n < 9000);
		`CHK(u_fld.steps, 2)
		`CHK(u_fld.dir, 1'b1)
	endtask : t_step
	task automatic t_events;
		for (int k = 0; k < 2; k++) begin
			bus(1, `FIO_ADDR_MODE, k ? 32'h50 : 32'h40);
			u_fld.pulse(0, 1);
			bus(0, `FIO_ADDR_STATUS, 32'h0);
			`CHK(d[k ? 4 : 2], 1'b1)
		end
		bus(1, `FIO_ADDR_CTRL, 32'h8);
		bus(1, `FIO_ADDR_TIMER, 32'h10);
		bus(1, `FIO_ADDR_MODE, 32'h40);
		repeat (20) @(posedge clk);
		bus(0, `FIO_ADDR_STATUS, 32'h0);
		`CHK(d[3], 1'b1)
	endtask : t_events
	task automatic tally_and_finish;
		$display("errors=%0d compares=%0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_defaults;
		t_count;
		t_updown;
		t_step;
		t_events;
		tally_and_finish;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			tally_and_finish;
		end
	end
endmodule : fast_io_mode_selector_bench
